/* rtl/tmr_pkg.sv */
// Package of register map, field layout and constants for the timer counter core
//
// What this block does
// - Up mode: overflow flag sets when counter rolls to zero after modulo.
// - Centre mode: flag sets at modulo, on the step down.
// - Flag clears only by status read while set, then writing zero.
// - New overflow during clear sequence restarts it; flag stays set.
// - Writing one to the flag leaves it unchanged.
// - Bit 6 enables interrupt request whenever the flag is one.
// - Centre select clear counts up; set counts up and down.
// - Clock field: none, bus clock, fixed system clock, external pin clock.
// - External and fixed clocks are synchronised to the bus clock.
// - Prescale field divides by two to the field value, 1 to 128.
// - Prescaler follows clock selection and synchronisation.
// - Reading either counter byte latches both until the next counter byte read.
// - Latch released by reset, counter write, or status register write.
// - Reset clears the counter.
// - Debug mode freezes counter and read latch, even on reads.
// - After modulo: restart at zero in up mode, count down in centre mode.
// - Writing one modulo byte suppresses overflow until the next modulo byte write.
// - Reset loads modulo with zero, counter free-running.
// - Any write to either counter byte resets the counter.
// - Modulo zero or all ones gives full-range free-running count.
package tmr_pkg;

   // ****************************************
   // Register byte addresses (one per word)
   // ****************************************
   localparam logic [3:0] TMR_ADR_STATUS_CONTROL = 4'h0;
   localparam logic [3:0] TMR_ADR_COUNTER_HIGH   = 4'h4;
   localparam logic [3:0] TMR_ADR_COUNTER_LOW    = 4'h8;
   localparam logic [3:0] TMR_ADR_MODULO_HIGH    = 4'hc;
   localparam logic [3:0] TMR_ADR_MODULO_LOW     = 4'h0; // at word 4, see upper bits
   localparam logic [4:0] TMR_ADR_MODULO_LOW_FULL = 5'h10;

   // ****************************************
   // Status/control field positions
   // ****************************************
   localparam int TMR_BIT_OVERFLOW_FLAG  = 7;
   localparam int TMR_BIT_IRQ_ENABLE     = 6;
   localparam int TMR_BIT_CENTER_SELECT  = 5;
   localparam int TMR_BIT_CLOCK_SEL_HI   = 4;
   localparam int TMR_BIT_CLOCK_SEL_LO   = 3;
   localparam int TMR_BIT_PRESCALE_HI    = 2;

   localparam logic [7:0]  TMR_STATUS_RESET  = 8'h00;
   localparam logic [15:0] TMR_COUNT_RESET   = 16'h0000;
   localparam logic [15:0] TMR_MODULO_RESET  = 16'h0000;
   localparam logic [15:0] TMR_COUNT_FULL    = 16'hffff;

   // ****************************************
   // Clock source encodings
   // ****************************************
   typedef enum logic [1:0] {
      TMR_CLK_NONE  = 2'b00,
      TMR_CLK_BUS   = 2'b01,
      TMR_CLK_FIXED = 2'b10,
      TMR_CLK_EXT   = 2'b11
   } tmr_clk_src_type;

   // Control fields grouped
   typedef struct packed {
      logic            irq_enable;
      logic            center_aligned_select;
      tmr_clk_src_type clock_select;
      logic [2:0]      prescale_select;
   } tmr_ctrl_type;

endpackage

/* rtl/tmr_core.sv */
// Timer counter core: status/control, counter with coherent reads, modulo
//
// Added by the designer: the address map and the Wishbone register port.
module tmr_core
   import tmr_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Clock sources and debug
   input  wire logic        fixed_system_clock,
   input  wire logic        external_timer_clock,
   input  wire logic        background_debug,
   // Outputs to channels and interrupt controller
   output logic             overflow_irq,
   output logic      [15:0] counter_value,
   output logic             center_aligned_pwm
);

   // ****************************************
   // Bus decode
   // ****************************************
   logic        req;
   logic        rd_stb;
   logic        wr_stb;
   logic        lane0;
   logic        sel_sc;
   logic        sel_cnth;
   logic        sel_cntl;
   logic        sel_modh;
   logic        sel_modl;

   // Only byte lane 0 carries data; one access per ack
   assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign lane0    = wb_sel_i[0];
   assign rd_stb   = req & ~wb_we_i;
   assign wr_stb   = req & wb_we_i & lane0;
   assign sel_sc   = (wb_adr_i == {1'b0, TMR_ADR_STATUS_CONTROL});
   assign sel_cnth = (wb_adr_i == {1'b0, TMR_ADR_COUNTER_HIGH});
   assign sel_cntl = (wb_adr_i == {1'b0, TMR_ADR_COUNTER_LOW});
   assign sel_modh = (wb_adr_i == {1'b0, TMR_ADR_MODULO_HIGH});
   assign sel_modl = (wb_adr_i == TMR_ADR_MODULO_LOW_FULL);

   // ****************************************
   // Control registers
   // ****************************************
   tmr_ctrl_type ctrl_r;
   logic         flag_r;
   logic         flag_armed_r;
   logic [15:0]  count_r;
   logic [15:0]  modulo_r;
   logic [7:0]   mod_hold_hi_r;
   logic         mod_pending_r;
   logic         down_r;
   logic [15:0]  latch_r;
   logic         latched_r;
   logic         ovf_event;
   logic         tick;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r <= tmr_ctrl_type'(TMR_STATUS_RESET[6:0]);
      end else if (wr_stb && sel_sc) begin
         ctrl_r <= tmr_ctrl_type'(wb_dat_i[6:0]);
      end
   end

   // ****************************************
   // Overflow flag and its clear sequence
   // ****************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flag_r       <= 1'b0;
         flag_armed_r <= 1'b0;
      end else if (ovf_event) begin
         // Set beats clear; pending clear restarts
         flag_r       <= 1'b1;
         flag_armed_r <= 1'b0;
      end else if (rd_stb && sel_sc && flag_r) begin
         flag_armed_r <= 1'b1;
      end else if (wr_stb && sel_sc && flag_armed_r &&
                   !wb_dat_i[TMR_BIT_OVERFLOW_FLAG]) begin
         flag_r       <= 1'b0;
         flag_armed_r <= 1'b0;
      end
      // Writing one falls through all branches and changes nothing
   end

   // ****************************************
   // Clock source synchronisers and select
   // ****************************************
   logic [2:0] ext_sync_r;
   logic [2:0] fix_sync_r;
   logic       src_tick;

   // Stage 0 read only by stage 1; rising edge taken from stages 1 and 2
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_sync_r <= 3'b000;
         fix_sync_r <= 3'b000;
      end else begin
         ext_sync_r <= {ext_sync_r[1:0], external_timer_clock};
         fix_sync_r <= {fix_sync_r[1:0], fixed_system_clock};
      end
   end

   // Pin limit keeps every pin edge visible to the synchroniser
   always_comb begin
      case (ctrl_r.clock_select)
         TMR_CLK_NONE:  src_tick = 1'b0;
         TMR_CLK_BUS:   src_tick = 1'b1;
         TMR_CLK_FIXED: src_tick = fix_sync_r[1] & ~fix_sync_r[2];
         TMR_CLK_EXT:   src_tick = ext_sync_r[1] & ~ext_sync_r[2];
         default:       src_tick = 1'b0;
      endcase
   end

   // ****************************************
   // Prescaler on the selected source
   // ****************************************
   logic [6:0] presc_r;
   logic [6:0] presc_mask;

   // Divide by 2**field: terminal when masked low bits are all ones
   assign presc_mask = 7'(({7'b0, 1'b1} << ctrl_r.prescale_select) - 8'd1);
   assign tick = src_tick && ((presc_r & presc_mask) == presc_mask)
                 && !background_debug;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         presc_r <= 7'h00;
      end else if (ctrl_r.clock_select == TMR_CLK_NONE) begin
         presc_r <= 7'h00;
      end else if (src_tick && !background_debug) begin
         presc_r <= 7'(presc_r + 7'd1);
      end
   end

   // ****************************************
   // Counter
   // ****************************************
   logic        at_top;
   logic        full_range;
   logic        cnt_wr;

   // Zero or all ones both mean the full 16-bit range
   assign full_range = (modulo_r == TMR_MODULO_RESET) || (modulo_r == TMR_COUNT_FULL);
   assign at_top     = full_range ? (count_r == TMR_COUNT_FULL) : (count_r == modulo_r);
   assign cnt_wr     = wr_stb && (sel_cnth || sel_cntl);
   assign ovf_event  = tick && at_top && !mod_pending_r
                       && (ctrl_r.center_aligned_select ? !down_r : 1'b1);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_r <= TMR_COUNT_RESET;
         down_r  <= 1'b0;
      end else if (cnt_wr) begin
         count_r <= TMR_COUNT_RESET;
         down_r  <= 1'b0;
      end else if (tick) begin
         if (!ctrl_r.center_aligned_select) begin
            down_r  <= 1'b0;
            count_r <= at_top ? TMR_COUNT_RESET : 16'(count_r + 16'd1);
         end else if (!down_r) begin
            if (at_top) begin
               down_r  <= 1'b1;
               count_r <= 16'(count_r - 16'd1);
            end else begin
               count_r <= 16'(count_r + 16'd1);
            end
         end else if (count_r == TMR_COUNT_RESET) begin
            down_r  <= 1'b0;
            count_r <= 16'(count_r + 16'd1);
         end else begin
            count_r <= 16'(count_r - 16'd1);
         end
      end
   end

   // ****************************************
   // Modulo register with byte pairing
   // ****************************************
   // High byte is staged and lands with the next low write, or at once while mod_pending_r is set; a low write alone loads modulo with the staged high byte
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         modulo_r      <= TMR_MODULO_RESET;
         mod_hold_hi_r <= TMR_MODULO_RESET[15:8];
         mod_pending_r <= 1'b0;
      end else if (wr_stb && sel_modh) begin
         mod_hold_hi_r <= wb_dat_i[7:0];
         mod_pending_r <= ~mod_pending_r;
         if (mod_pending_r) begin
            modulo_r <= {wb_dat_i[7:0], modulo_r[7:0]};
         end
      end else if (wr_stb && sel_modl) begin
         mod_pending_r <= ~mod_pending_r;
         modulo_r      <= {mod_hold_hi_r, wb_dat_i[7:0]};
      end
   end

   // ****************************************
   // Coherent counter read latch
   // ****************************************
   logic cnt_rd;
   assign cnt_rd = rd_stb && (sel_cnth || sel_cntl) && !background_debug;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         latch_r   <= TMR_COUNT_RESET;
         latched_r <= 1'b0;
      end else if (cnt_wr || (wr_stb && sel_sc)) begin
         latched_r <= 1'b0;
      end else if (cnt_rd) begin
         // Frozen in debug: cnt_rd is held off
         if (!latched_r) begin
            latch_r   <= count_r;
            latched_r <= 1'b1;
         end else begin
            latched_r <= 1'b0;
         end
      end
   end

   // ****************************************
   // Read data and acknowledge
   // ****************************************
   logic [15:0] rd_cnt;
   logic [7:0]  rd_byte;

   assign rd_cnt = latched_r ? latch_r : count_r;

   always_comb begin
      rd_byte = 8'h00;
      if (sel_sc) begin
         rd_byte = {flag_r, ctrl_r};
      end else if (sel_cnth) begin
         rd_byte = rd_cnt[15:8];
      end else if (sel_cntl) begin
         rd_byte = rd_cnt[7:0];
      end else if (sel_modh) begin
         rd_byte = modulo_r[15:8];
      end else if (sel_modl) begin
         rd_byte = modulo_r[7:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= rd_stb ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         overflow_irq       <= 1'b0;
         counter_value      <= TMR_COUNT_RESET;
         center_aligned_pwm <= 1'b0;
      end else begin
         overflow_irq       <= flag_r && ctrl_r.irq_enable;
         counter_value      <= count_r;
         center_aligned_pwm <= ctrl_r.center_aligned_select;
      end
   end

endmodule

/* bench/tmr_core_chk.sv */
// Checker of bus handshake and counter stepping of the timer core
module tmr_core_chk (
   // Clock and reset
   input wire logic        clk,
   input wire logic        sys_rst,
   // Bus and side inputs
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [4:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic        fixed_system_clock,
   input wire logic        external_timer_clock,
   input wire logic        background_debug,
   // Outputs watched
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        overflow_irq,
   input wire logic [15:0] counter_value,
   input wire logic        center_aligned_pwm
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire logic cnt_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i inside {5'h04, 5'h08};
   sequence s_up_mode;
      !center_aligned_pwm [*3];
   endsequence
   sequence s_moved;
      counter_value != $past(counter_value);
   endsequence
   a_ack_answer: assert property (take |=> wb_ack_o)
      else $error("Request not answered");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Ack held too long");
   a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("Upper read bits set");
   a_cnt_clear: assert property (cnt_wr |-> ##[1:3] counter_value == 16'h0000)
      else $error("Counter write did not clear");
   a_debug_freeze: assert property (
      (background_debug && !wb_cyc_i) [*3] |-> $stable(counter_value))
      else $error("Counter moved in debug");
   a_step_unit: assert property (
      s_moved |-> counter_value == $past(counter_value) + 16'h0001
         || counter_value == $past(counter_value) - 16'h0001 || counter_value == 16'h0000)
      else $error("Counter jumped");
   a_up_step: assert property (
      s_up_mode ##0 s_moved |-> counter_value == $past(counter_value) + 16'h0001
         || counter_value == 16'h0000)
      else $error("Up mode step wrong");
   a_rst_zero: assert property (
      $fell(sys_rst) |-> counter_value == 16'h0000 && !overflow_irq)
      else $error("Outputs not clear after reset");
endmodule

bind tmr_core tmr_core_chk u_chk (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .fixed_system_clock, .external_timer_clock, .background_debug,
   .wb_dat_o, .wb_ack_o, .overflow_irq, .counter_value, .center_aligned_pwm);

/* bench/tmr_core_tb_top.sv */
// Testbench of the timer core: bus tasks and register scenarios
module tmr_core_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, sys_rst = 1'b1, background_debug = 1'b0;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [4:0]  wb_adr_i = 5'h00;
   logic [3:0]  wb_sel_i = 4'hf, sel_v = 4'hf, ph = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
   logic        fixed_system_clock = 1'b0, external_timer_clock = 1'b0;
   logic        overflow_irq, center_aligned_pwm, ok;
   logic [15:0] counter_value, c, mx, mn;
   logic [7:0]  rv;
   int          bad_count = 0, comparisons = 0, cycles = 0, e;

   tmr_core dut (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .fixed_system_clock, .external_timer_clock,
      .background_debug, .overflow_irq, .counter_value, .center_aligned_pwm);

   always #12.5 clk = ~clk;
   // Pin clocks at an eighth and a sixteenth of bus rate
   always @(posedge clk) begin
      ph <= ph + 4'h1;
      fixed_system_clock <= ph[2];
      external_timer_clock <= ph[3];
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         bad_count++;
         summarize();
      end
   end

   task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= sel_v;
      wb_dat_i <= 32'(d);
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rv = wb_dat_o[7:0];
      if (n >= 20) bad_count++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic chk(input string nm, input logic [15:0] s, x);
      comparisons++;
      if (s !== x) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, x, s);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Stop the clock, then a proper clear sequence
   task automatic stop_clear;
      bus(5'h00, 1'b1, 8'hc0);
      bus(5'h00, 1'b0, 8'h00);
      bus(5'h00, 1'b1, 8'h00);
   endtask

   task automatic summarize;
      $display("Checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      // Last address is unmapped and reads zero
      for (int i = 0; i < 6; i++) begin
         bus(5'(i * 4), 1'b0, 8'h00);
         chk("rst", rv, 16'h0000);
      end
      bus(5'h0c, 1'b1, 8'h00);
      bus(5'h10, 1'b1, 8'h05);
      bus(5'h00, 1'b1, 8'h48);
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         chk("range", 16'(counter_value <= 16'h0005), 16'h0001);
      end
      chk("ovf", 16'(overflow_irq), 16'h0001);
      bus(5'h00, 1'b1, 8'h40);
      idle(2);
      chk("noread", 16'(overflow_irq), 16'h0001);
      bus(5'h00, 1'b1, 8'hc0);
      bus(5'h00, 1'b0, 8'h00);
      chk("sc", rv, 16'h00c0);
      bus(5'h00, 1'b1, 8'h40);
      idle(2);
      chk("clr", 16'(overflow_irq), 16'h0000);
      bus(5'h0c, 1'b1, 8'h00);
      bus(5'h00, 1'b1, 8'h48);
      idle(30);
      chk("half", 16'(overflow_irq), 16'h0000);
      // Counter zeroed first so the new, smaller modulo is met at once
      bus(5'h04, 1'b1, 8'h00);
      bus(5'h10, 1'b1, 8'h03);
      idle(12);
      chk("full", 16'(overflow_irq), 16'h0001);
      // Two reads so at least one arms; later overflows must disarm
      bus(5'h00, 1'b0, 8'h00);
      bus(5'h00, 1'b0, 8'h00);
      idle(8);
      bus(5'h00, 1'b1, 8'h00);
      bus(5'h00, 1'b0, 8'h00);
      chk("restart", rv, 16'h0080);
      chk("mask", 16'(overflow_irq), 16'h0000);
      stop_clear();
      bus(5'h04, 1'b1, 8'h5a);
      bus(5'h00, 1'b1, 8'h68);
      mx = 16'h0000;
      mn = 16'hffff;
      for (int i = 0; i < 30; i++) begin
         @(posedge clk);
         if (counter_value > mx) mx = counter_value;
         if (counter_value < mn) mn = counter_value;
      end
      chk("top", mx, 16'h0003);
      chk("bottom", mn, 16'h0000);
      chk("csel", 16'(center_aligned_pwm), 16'h0001);
      chk("cflag", 16'(overflow_irq), 16'h0001);
      stop_clear();
      bus(5'h0c, 1'b1, 8'h00);
      bus(5'h10, 1'b1, 8'h00);
      // Eight prescales, fixed clock, pin clock, no clock; no channel shares the pin
      for (int i = 0; i < 11; i++) begin
         bus(5'h00, 1'b1, i < 8 ? 8'(8 + i) : (i < 10 ? 8'((i - 6) * 8) : 8'h00));
         bus(5'h04, 1'b1, 8'h00);
         idle(512);
         bus(5'h00, 1'b1, 8'h00);
         idle(4);
         e = i < 8 ? 512 >> i : (i == 8 ? 64 : (i == 9 ? 32 : 0));
         ok = counter_value + 2 >= e && counter_value <= e + (i == 0 ? 10 : 3);
         chk("rate", 16'(ok), 16'h0001);
      end
      bus(5'h00, 1'b1, 8'h08);
      bus(5'h04, 1'b1, 8'h00);
      bus(5'h08, 1'b0, 8'h00);
      idle(300);
      bus(5'h04, 1'b0, 8'h00);
      chk("latch", rv, 16'h0000);
      bus(5'h08, 1'b0, 8'h00);
      bus(5'h00, 1'b1, 8'h08);
      idle(300);
      bus(5'h04, 1'b0, 8'h00);
      chk("release", 16'(rv != 8'h00), 16'h0001);
      bus(5'h04, 1'b1, 8'h00);
      bus(5'h08, 1'b0, 8'h00);
      background_debug <= 1'b1;
      idle(3);
      c = counter_value;
      idle(50);
      chk("frozen", counter_value, c);
      bus(5'h04, 1'b0, 8'h00);
      background_debug <= 1'b0;
      idle(300);
      bus(5'h04, 1'b0, 8'h00);
      chk("dbglatch", rv, 16'h0000);
      sel_v = 4'he;
      bus(5'h0c, 1'b1, 8'h55);
      sel_v = 4'hf;
      bus(5'h0c, 1'b0, 8'h00);
      chk("sel", rv, 16'h0000);
      summarize();
   end
endmodule
